// *** core/rtcca_core.v ***
`include "rtcca_regs.vh"

module rtcca_core #(
    parameter TICK_CYC = `RTCCA_TICK_CYC,
    parameter AUTOCLR_CYC = `RTCCA_AUTOCLR_CYC
) (
    input wire clock,
    input wire rst_n,
    input wire nobat_rst_n,
    input wire clk_en,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire ta_unlock,
    input wire [7:0] alarm_subsecond,
    input wire [5:0] alarm_second,
    input wire min_match,
    input wire hour_match,
    input wire rtc_irq_enable,
    output reg [7:0] sfr_rdata_reg,
    output reg rtc_irq_reg,
    output reg min_carry_reg,
    output reg time_read_en_reg,
    output reg time_write_en_reg
);
    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function sel;
        input [7:0] addr;
        input [7:0] off;
        begin
            sel = (addr == off);
        end
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    // Battery-backed state (only the no-battery reset touches it), then the access enable next values
    reg [3:0] cmp_en_reg;
    reg [3:0] cmp_en_next;
    reg alarm_flag_reg;
    reg alarm_flag_next;
    reg osc_en_reg;
    reg osc_en_next;
    reg time_read_en_next;
    reg time_write_en_next;
    // Timekeeping
    reg [16:0] presc_reg;
    reg [7:0] subsec_reg;
    reg [5:0] second_reg;
    reg [7:0] snap_subsec_reg;
    reg [5:0] snap_second_reg;
    reg eval_reg;
    reg [7:0] rdata_next;
    wire any_rst_n;
    wire ctl_wr;
    wire sec_wr;
    wire both_set;
    wire tick;
    wire step;
    wire expire;
    wire hit;
    wire we_fall;

    // Either reset clears the access enables. The two resets are
    // merged in plain logic; both are level inputs held for at least
    // one edge, so a short glitch on the merged net is not a concern.
    // The battery-backed bits deliberately do not see this net, since
    // an ordinary reset must leave the alarm setup and the oscillator
    // running untouched.
    assign any_rst_n = rst_n & nobat_rst_n;

    assign ctl_wr = clk_en && sfr_wr && sel(sfr_addr, `RTCCA_OFF_CONTROL);
    assign sec_wr = clk_en && sfr_wr && sel(sfr_addr, `RTCCA_OFF_SECOND);
    assign both_set = sfr_wdata[`RTCCA_BIT_READ_EN]
        && sfr_wdata[`RTCCA_BIT_WRITE_EN];

    // ------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------
    // One timer serves both windows; it counts while either one is open
    rtcca_win_timer #(
        .LIMIT(AUTOCLR_CYC)
    ) u_win (
        .clock(clock),
        .rst_n(any_rst_n),
        .clk_en(clk_en),
        .run(time_read_en_reg | time_write_en_reg),
        .expire_reg(expire)
    );

    rtcca_alarm_cmp u_cmp (
        .clock(clock),
        .rst_n(nobat_rst_n),
        .clk_en(clk_en),
        .eval(eval_reg),
        .cmp_en(cmp_en_reg),
        .subsec(subsec_reg),
        .alarm_subsecond(alarm_subsecond),
        .second(second_reg),
        .alarm_second(alarm_second),
        .min_match(min_match),
        .hour_match(hour_match),
        .hit_reg(hit)
    );

    // ------------------------------------------------------------
    // Control register next state
    // ------------------------------------------------------------
    // Compare enables and alarm flag with set-over-clear priority
    always @* begin
        cmp_en_next = cmp_en_reg;
        if (ctl_wr) begin
            cmp_en_next = sfr_wdata[7:4];
        end
        alarm_flag_next = alarm_flag_reg;
        if (ctl_wr && !sfr_wdata[`RTCCA_BIT_ALARM]) begin
            alarm_flag_next = 1'b0; // Writing one is a no-op
        end
        if (cmp_en_next == `RTCCA_RST_CMP_EN) begin
            alarm_flag_next = 1'b0;
        end
        if (hit) begin
            alarm_flag_next = 1'b1; // Only a match sets it
        end
    end

    // Oscillator enable moves only with the unlock held
    always @* begin
        osc_en_next = osc_en_reg;
        if (ctl_wr && ta_unlock) begin
            osc_en_next = sfr_wdata[`RTCCA_BIT_OSC_EN];
        end
    end

    // Access enables; a write asking for both leaves both alone.
    // Auto-clear wins over a software write in the same cycle, so a
    // window can never outlive its limit by a late write.
    // Spacing between enable changes is left to software.
    always @* begin
        time_read_en_next = time_read_en_reg;
        time_write_en_next = time_write_en_reg;
        if (ctl_wr && !both_set) begin
            time_read_en_next = sfr_wdata[`RTCCA_BIT_READ_EN];
            if (ta_unlock) begin
                time_write_en_next = sfr_wdata[`RTCCA_BIT_WRITE_EN];
            end
        end
        if (expire) begin
            time_read_en_next = 1'b0;
            time_write_en_next = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control register storage
    // ------------------------------------------------------------
    // Kept through ordinary resets so the alarm setup survives
    always @(posedge clock or negedge nobat_rst_n) begin
        if (!nobat_rst_n) begin
            cmp_en_reg <= `RTCCA_RST_CMP_EN;
            alarm_flag_reg <= 1'b0;
            osc_en_reg <= 1'b0;
        end else if (clk_en) begin
            cmp_en_reg <= cmp_en_next;
            alarm_flag_reg <= alarm_flag_next;
            osc_en_reg <= osc_en_next;
        end
    end

    // Access enables drop on any reset
    always @(posedge clock or negedge any_rst_n) begin
        if (!any_rst_n) begin
            time_read_en_reg <= 1'b0;
            time_write_en_reg <= 1'b0;
        end else if (clk_en) begin
            time_read_en_reg <= time_read_en_next;
            time_write_en_reg <= time_write_en_next;
        end
    end

    // ------------------------------------------------------------
    // Subsecond prescaler
    // ------------------------------------------------------------
    // Stands in for the oscillator; stopped when it is disabled
    always @(posedge clock or negedge nobat_rst_n) begin
        if (!nobat_rst_n) begin
            presc_reg <= 17'h00000;
        end else if (clk_en) begin
            if (!osc_en_reg) begin
                presc_reg <= 17'h00000;
            end else if (tick) begin
                presc_reg <= 17'h00000;
            end else begin
                presc_reg <= presc_reg + 17'h00001;
            end
        end
    end

    assign tick = osc_en_reg && (presc_reg == TICK_CYC[16:0] - 17'h00001);
    // Counters stand still while the write window is open
    assign step = tick && !time_write_en_reg;
    assign we_fall = time_write_en_reg && !time_write_en_next;

    // ------------------------------------------------------------
    // Time counters
    // ------------------------------------------------------------
    // A tick during a write window is dropped; software is setting
    // the time anyway, so nothing it cares about is lost
    always @(posedge clock or negedge nobat_rst_n) begin
        if (!nobat_rst_n) begin
            subsec_reg <= `RTCCA_RST_SUBSEC;
            second_reg <= `RTCCA_RST_SECOND;
            min_carry_reg <= 1'b0;
            eval_reg <= 1'b0;
        end else if (clk_en) begin
            min_carry_reg <= 1'b0;
            eval_reg <= step;
            if (we_fall) begin
                subsec_reg <= `RTCCA_RST_SUBSEC;
            end else if (step) begin
                subsec_reg <= subsec_reg + 8'h01; // Wraps ff to 00
            end
            if (sec_wr && time_write_en_reg) begin
                second_reg <= sfr_wdata[5:0];
            end else if (step && subsec_reg == 8'hff) begin
                if (second_reg == `RTCCA_SECOND_MAX) begin
                    second_reg <= `RTCCA_RST_SECOND;
                    min_carry_reg <= 1'b1;
                end else begin
                    second_reg <= second_reg + 6'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Visible time snapshot
    // ------------------------------------------------------------
    // Tracks the counters until the read window opens, then holds
    always @(posedge clock or negedge nobat_rst_n) begin
        if (!nobat_rst_n) begin
            snap_subsec_reg <= `RTCCA_RST_SUBSEC;
            snap_second_reg <= `RTCCA_RST_SECOND;
        end else if (clk_en && !time_read_en_reg) begin
            snap_subsec_reg <= subsec_reg;
            snap_second_reg <= second_reg;
        end
    end

    // ------------------------------------------------------------
    // Read path and interrupt request
    // ------------------------------------------------------------
    // Outside a read window the snapshot may be mid-update
    always @* begin
        rdata_next = 8'h00;
        if (sel(sfr_addr, `RTCCA_OFF_CONTROL)) begin
            rdata_next = {cmp_en_reg, time_read_en_reg, time_write_en_reg,
                alarm_flag_reg, osc_en_reg};
        end else if (sel(sfr_addr, `RTCCA_OFF_SUBSEC)) begin
            rdata_next = snap_subsec_reg;
        end else if (sel(sfr_addr, `RTCCA_OFF_SECOND)) begin
            rdata_next = {2'b00, snap_second_reg};
        end
    end

    // Read data held until the next read; request follows the flag while rtc_irq_enable is high
    always @(posedge clock or negedge any_rst_n) begin
        if (!any_rst_n) begin
            sfr_rdata_reg <= 8'h00;
            rtc_irq_reg <= 1'b0;
        end else if (clk_en) begin
            if (sfr_rd) begin
                sfr_rdata_reg <= rdata_next;
            end
            rtc_irq_reg <= alarm_flag_reg && rtc_irq_enable;
        end
    end
endmodule

// *** pkg/rtcca_regs.vh ***
`ifndef RTCCA_REGS_VH
`define RTCCA_REGS_VH

// ----------------------------------------------------------------
// Register offsets on the special function register bus
// ----------------------------------------------------------------
`define RTCCA_OFF_CONTROL 8'hf9
`define RTCCA_OFF_SUBSEC 8'hfa
`define RTCCA_OFF_SECOND 8'hfb

// ----------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------
`define RTCCA_BIT_SUBSEC_CMP 7
`define RTCCA_BIT_SEC_CMP 6
`define RTCCA_BIT_MIN_CMP 5
`define RTCCA_BIT_HOUR_CMP 4
`define RTCCA_BIT_READ_EN 3
`define RTCCA_BIT_WRITE_EN 2
`define RTCCA_BIT_ALARM 1
`define RTCCA_BIT_OSC_EN 0

// ----------------------------------------------------------------
// Reset values and counter limits
// ----------------------------------------------------------------
`define RTCCA_RST_CMP_EN 4'h0
`define RTCCA_RST_SUBSEC 8'h00
`define RTCCA_RST_SECOND 6'h00
`define RTCCA_SECOND_MAX 6'h3b

// ----------------------------------------------------------------
// Timing: figures in their own units, cycle counts derived
// ----------------------------------------------------------------
`define RTCCA_CLK_NS 50
`define RTCCA_TICK_NS 3906250
`define RTCCA_WINDOW_US 1000
`define RTCCA_AUTOCLR_US 1950
`define RTCCA_TICK_CYC (`RTCCA_TICK_NS / `RTCCA_CLK_NS)
`define RTCCA_AUTOCLR_CYC ((`RTCCA_AUTOCLR_US * 1000) / `RTCCA_CLK_NS)

`endif

// *** core/rtcca_win_timer.v ***
`include "rtcca_regs.vh"

// ----------------------------------------------------------------
// Access window timer: pulses once when the window has run too long
// ----------------------------------------------------------------
module rtcca_win_timer #(
    parameter LIMIT = `RTCCA_AUTOCLR_CYC
) (
    input wire clock,
    input wire rst_n,
    input wire clk_en,
    input wire run,
    output reg expire_reg
);
    reg [15:0] count_reg;

    // Count while a window is open; restart from zero when it closes
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 16'h0000;
            expire_reg <= 1'b0;
        end else if (clk_en) begin
            expire_reg <= 1'b0;
            if (!run) begin
                count_reg <= 16'h0000;
            end else if (count_reg == LIMIT[15:0] - 16'h0001) begin
                count_reg <= 16'h0000;
                expire_reg <= 1'b1; // Lands after the longest window has ended
            end else begin
                count_reg <= count_reg + 16'h0001;
            end
        end
    end
endmodule

// *** core/rtcca_alarm_cmp.v ***
`include "rtcca_regs.vh"

// ----------------------------------------------------------------
// Alarm compare: one-cycle hit when at least one field is enabled and every enabled field matches
// ----------------------------------------------------------------
module rtcca_alarm_cmp (
    input wire clock,
    input wire rst_n,
    input wire clk_en,
    input wire eval,
    input wire [3:0] cmp_en,
    input wire [7:0] subsec,
    input wire [7:0] alarm_subsecond,
    input wire [5:0] second,
    input wire [5:0] alarm_second,
    input wire min_match,
    input wire hour_match,
    output reg hit_reg
);
    wire ss_ok;
    wire s_ok;
    wire m_ok;
    wire h_ok;

    // A cleared enable makes its field a don't care
    assign ss_ok = !cmp_en[3] || (subsec == alarm_subsecond);
    assign s_ok = !cmp_en[2] || (second == alarm_second);
    assign m_ok = !cmp_en[1] || min_match;
    assign h_ok = !cmp_en[0] || hour_match;

    // Evaluated once per counter step, so a standing match repeats
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hit_reg <= 1'b0;
        end else if (clk_en) begin
            hit_reg <= eval && (|cmp_en) && ss_ok && s_ok && m_ok && h_ok;
        end
    end
endmodule

// *** tb/rtcca_chk.sv ***
module rtcca_chk #(
    parameter AUTOCLR_CYC = 40
) (
    input wire clock,
    input wire rst_n,
    input wire nobat_rst_n,
    input wire clk_en,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire ta_unlock,
    input wire rtc_irq_enable,
    input wire [7:0] sfr_rdata_reg,
    input wire rtc_irq_reg,
    input wire min_carry_reg,
    input wire time_read_en_reg,
    input wire time_write_en_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n || !nobat_rst_n);
    // --------
    // Helpers
    // --------
    logic [15:0] win_cnt_reg;
    wire ctl_wr = sfr_wr && clk_en && sfr_addr == 8'hf9;
    wire ren_req = ctl_wr && sfr_wdata[3] && !sfr_wdata[2];
    wire wen_req = ctl_wr && ta_unlock && sfr_wdata[2] && !sfr_wdata[3];
    // Open-window length; unbounded growth means auto-clear is dead
    always @(posedge clock or negedge rst_n or negedge nobat_rst_n) begin
        if (!rst_n || !nobat_rst_n)
            win_cnt_reg <= 16'h0000;
        else if (!(time_read_en_reg || time_write_en_reg))
            win_cnt_reg <= 16'h0000;
        else if (clk_en)
            win_cnt_reg <= win_cnt_reg + 16'h0001;
    end
    sequence s_both_req;
        ctl_wr && sfr_wdata[3:2] == 2'b11
            ##0 !time_read_en_reg && !time_write_en_reg;
    endsequence
    sequence s_rd_sec;
        sfr_rd && clk_en && sfr_addr == 8'hfb;
    endsequence
    // --------
    // Properties
    // --------
    chk_both_set_ignored: assert property (
        s_both_req |=> !time_read_en_reg && !time_write_en_reg)
        else $error("both enables set by one write");
    chk_wen_needs_unlock: assert property (
        $rose(time_write_en_reg) |-> $past(wen_req))
        else $error("write enable rose without unlocked write");
    chk_ren_rise_cause: assert property (
        $rose(time_read_en_reg) |-> $past(ren_req))
        else $error("read enable rose without a write");
    chk_window_bound: assert property (
        win_cnt_reg <= AUTOCLR_CYC + 4)
        else $error("access window not closed in time");
    chk_irq_needs_en: assert property (
        rtc_irq_reg && $past(clk_en) |-> $past(rtc_irq_enable))
        else $error("interrupt without enable");
    chk_irq_drop_en: assert property (
        !rtc_irq_enable && clk_en |=> !rtc_irq_reg)
        else $error("interrupt kept after enable low");
    chk_carry_one_cycle: assert property (
        min_carry_reg && clk_en |=> !min_carry_reg)
        else $error("minute carry longer than one cycle");
    chk_sec_upper_zero: assert property (
        s_rd_sec |=> sfr_rdata_reg[7:6] == 2'b00)
        else $error("second upper bits not zero");
endmodule

// *** tb/rtcca_cpu_model.sv ***
module rtcca_cpu_model (
    input wire clock,
    input wire [7:0] sfr_rdata_reg,
    output logic [7:0] sfr_addr,
    output logic [7:0] sfr_wdata,
    output logic sfr_wr,
    output logic sfr_rd,
    output logic ta_unlock
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bus idle at start
    initial begin
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        ta_unlock = 1'b0;
    end
    // One transfer, held until the taking edge
    task automatic cycle(input logic [7:0] a, input logic [7:0] d,
                         input logic w, input logic u);
        @(posedge clock);
        #5;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = w;
        sfr_rd = !w;
        ta_unlock = u;
        @(posedge clock);
        #5;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        ta_unlock = 1'b0;
        // Released lines must not look like the old value
        sfr_addr = ~a;
        sfr_wdata = ~d;
    endtask
    // Control writes that set an enable bit are spaced by 4 machine cycles (16 clocks)
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic u);
        if (a == 8'hf9 && d[3:2] != 2'b00) repeat (16) @(posedge clock);
        cycle(a, d, 1'b1, u);
        if (a == 8'hf9 && d[3:2] != 2'b00) repeat (16) @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        cycle(a, 8'h00, 1'b0, 1'b0);
        q = sfr_rdata_reg;
    endtask
endmodule

// *** tb/tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic nobat_rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] alarm_subsecond = 8'hff;
    logic [5:0] alarm_second = 6'h00;
    logic min_match = 1'b0;
    logic hour_match = 1'b0;
    logic rtc_irq_enable = 1'b0;
    wire [7:0] sfr_addr, sfr_wdata, sfr_rdata_reg;
    wire sfr_wr, sfr_rd, ta_unlock, rtc_irq_reg, min_carry_reg;
    wire time_read_en_reg, time_write_en_reg;
    int miscompares = 0;
    int samples_checked = 0;
    logic [7:0] q, q2;
    int n;
    rtcca_core #(.TICK_CYC(16), .AUTOCLR_CYC(40)) DUT (
        .clock(clock), .rst_n(rst_n), .nobat_rst_n(nobat_rst_n),
        .clk_en(clk_en), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .ta_unlock(ta_unlock),
        .alarm_subsecond(alarm_subsecond), .alarm_second(alarm_second),
        .min_match(min_match), .hour_match(hour_match),
        .rtc_irq_enable(rtc_irq_enable), .sfr_rdata_reg(sfr_rdata_reg),
        .rtc_irq_reg(rtc_irq_reg), .min_carry_reg(min_carry_reg),
        .time_read_en_reg(time_read_en_reg),
        .time_write_en_reg(time_write_en_reg));
    rtcca_cpu_model cpu (
        .clock(clock), .sfr_rdata_reg(sfr_rdata_reg),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .ta_unlock(ta_unlock));
    // Clock, 50 ns period
    initial forever #25 clock = ~clock;
    // --------
    // Checking helpers
    // --------
    task automatic cmp(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Cycles with interrupt high over a span
    task automatic watch(input int span, output int c);
        c = 0;
        repeat (span) begin
            @(posedge clock);
            #1;
            if (rtc_irq_reg === 1'b1) c++;
        end
    endtask
    task automatic results;
        $display("checks %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // --------
    // Scenarios
    // --------
    task automatic t_reset_osc;
        cpu.rd(8'hf9, q);
        cmp("control after reset", 8'h00, q);
        cpu.wr(8'hf9, 8'h01, 1'b0);
        cpu.rd(8'hf9, q);
        cmp("osc without unlock", 8'h00, q);
        cpu.wr(8'hf9, 8'h01, 1'b1);
        cpu.rd(8'hf9, q);
        cmp("osc with unlock", 8'h01, q);
        cpu.wr(8'hf9, 8'h0d, 1'b1);
        cpu.rd(8'hf9, q);
        cmp("both enables", 8'h01, q);
        $display("test reset_osc done");
    endtask
    task automatic t_write_window;
        repeat (300) @(posedge clock);
        cpu.wr(8'hfb, 8'h3b, 1'b0);
        cpu.wr(8'hf9, 8'h09, 1'b0);
        cpu.rd(8'hfb, q);
        cmp("second write while closed", 8'h00, q);
        cpu.wr(8'hf9, 8'h01, 1'b0);
        cpu.wr(8'hf9, 8'h05, 1'b1);
        cmp("write window open", 8'h01, {7'h00, time_write_en_reg});
        cpu.wr(8'hfa, 8'h55, 1'b0);
        cpu.wr(8'hfb, 8'h3b, 1'b0);
        cpu.wr(8'hf9, 8'h01, 1'b1);
        cpu.rd(8'hfa, q);
        cmp("subsecond cleared", 8'h00, q & 8'hfe);
        n = 0;
        while (min_carry_reg !== 1'b1 && n < 5000) begin
            @(posedge clock);
            #1;
            n++;
        end
        cmp("carry time", 8'h01, {7'h00, n > 3900 && n < 4200});
        cpu.wr(8'hf9, 8'h09, 1'b0);
        cpu.rd(8'hfb, q);
        cmp("second wrapped", 8'h00, q);
        $display("test write_window done");
    endtask
    task automatic t_read_window;
        n = 0;
        while (time_read_en_reg === 1'b1 && n < 100) begin
            @(posedge clock);
            #1;
            n++;
        end
        cmp("read window auto close", 8'h01, {7'h00, n <= 40});
        cpu.wr(8'hf9, 8'h09, 1'b0);
        cpu.rd(8'hfa, q);
        repeat (10) @(posedge clock);
        cpu.rd(8'hfa, q2);
        cmp("frozen subsecond", q, q2);
        cmp("read window held", 8'h01, {7'h00, time_read_en_reg});
        $display("test read_window done");
    endtask
    task automatic t_alarm;
        rtc_irq_enable = 1'b1;
        cpu.wr(8'hf9, 8'h41, 1'b0);
        watch(40, n);
        cmp("second alarm", 8'h01, {7'h00, n > 0});
        cpu.rd(8'hf9, q);
        cmp("flag set", 8'h43, q);
        cpu.wr(8'hf9, 8'h41, 1'b0);
        watch(48, n);
        cmp("alarm per tick", 8'h01, {7'h00, n > 0 && n < 48});
        // Second write lands after any hit still in the compare pipe
        cpu.wr(8'hf9, 8'h61, 1'b0);
        cpu.wr(8'hf9, 8'h61, 1'b0);
        watch(64, n);
        cmp("minute gate", 8'h00, n[7:0]);
        cpu.wr(8'hf9, 8'h63, 1'b0);
        watch(32, n);
        cmp("software flag set", 8'h00, n[7:0]);
        cpu.wr(8'hf9, 8'h11, 1'b0);
        min_match = 1'b1;
        watch(40, n);
        cmp("hour gate", 8'h00, n[7:0]);
        hour_match = 1'b1;
        watch(40, n);
        cmp("hour alarm", 8'h01, {7'h00, n > 0});
        @(posedge clock);
        #5 rst_n = 1'b0;
        repeat (2) @(posedge clock);
        #5 rst_n = 1'b1;
        cpu.rd(8'hf9, q);
        cmp("control kept by reset", 8'h13, q);
        cpu.wr(8'hf9, 8'h03, 1'b0);
        cpu.rd(8'hf9, q);
        cmp("enables off clear flag", 8'h01, q);
        $display("test alarm done");
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge clock);
        #5;
        nobat_rst_n = 1'b1;
        rst_n = 1'b1;
        t_reset_osc();
        t_write_window();
        t_read_window();
        t_alarm();
        results();
    end
    // Watchdog, about eight times the expected run
    initial begin
        #2000000;
        miscompares++;
        results();
    end
endmodule
bind rtcca_core rtcca_chk #(.AUTOCLR_CYC(AUTOCLR_CYC)) u_chk (
    .clock(clock), .rst_n(rst_n), .nobat_rst_n(nobat_rst_n),
    .clk_en(clk_en), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .ta_unlock(ta_unlock),
    .rtc_irq_enable(rtc_irq_enable), .sfr_rdata_reg(sfr_rdata_reg),
    .rtc_irq_reg(rtc_irq_reg), .min_carry_reg(min_carry_reg),
    .time_read_en_reg(time_read_en_reg),
    .time_write_en_reg(time_write_en_reg));
